// >>> hmpc_pkg.sv
// constants, codes and carrier types for the hall pattern control block
package hmpc_pkg;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0]  OFS_MODCTL   = 8'h00;
	localparam logic [7:0]  OFS_PCTRL    = 8'h04;
	localparam logic [7:0]  OFS_SHADOW   = 8'h08;
	localparam logic [7:0]  OFS_ACTIVE   = 8'h0C;
	localparam logic [7:0]  OFS_STATUS   = 8'h10;
	localparam logic [7:0]  OFS_DTRELOAD = 8'h14;

	// ------------------------------------------------------------
	// reset values and masks
	// ------------------------------------------------------------
	localparam logic [15:0] MODCTL_RST   = 16'h0000;
	localparam logic [15:0] MODCTL_WMASK = 16'hBFBF;
	localparam logic [7:0]  DT_RELOAD_RST = 8'h04;
	localparam logic [2:0]  SEL_RST      = 3'h0;
	localparam logic [1:0]  SYN_RST      = 2'h0;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int MC_ECT      = 15;
	localparam int MC_TB_LSB   = 8;
	localparam int MC_EN       = 7;
	localparam int MC_TA_LSB   = 0;
	localparam int PC_SEL_LSB  = 0;
	localparam int PC_SYN_LSB  = 4;
	localparam int SH_PAT_LSB  = 0;
	localparam int SH_PREQ     = 7;
	localparam int SH_EXP_LSB  = 8;
	localparam int SH_CUR_LSB  = 11;
	localparam int SH_HREQ     = 15;
	localparam int ST_XFER     = 0;
	localparam int ST_CHE      = 1;
	localparam int ST_WHE      = 2;
	localparam int ST_REM      = 3;
	localparam int ST_HALL_LSB = 4;

	// ------------------------------------------------------------
	// codes
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		TRG_NONE   = 3'b000,
		TRG_CHE    = 3'b001,
		TRG_TB_PM  = 3'b010,
		TRG_TA_OM  = 3'b011,
		TRG_CH1_UP = 3'b100,
		TRG_TA_PM  = 3'b101
	} hmpc_trig_t;

	typedef enum logic [1:0] {
		SYN_DIRECT = 2'b00,
		SYN_TB_ZM  = 2'b01,
		SYN_TA_ZM  = 2'b10,
		SYN_RSVD   = 2'b11
	} hmpc_sync_t;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic tb_period;
		logic ta_one_down;
		logic ta_ch1_up;
		logic ta_period_up;
		logic tb_zero;
		logic ta_zero_up;
	} hmpc_tmr_ev_t;

	typedef struct packed {
		logic [5:0] pat;
		logic [2:0] exp;
		logic [2:0] cur;
	} hmpc_pattern_t;

endpackage

// >>> hmpc_hall_filter.sv
// hall edge detection and dead-time delay producing the compare ready strobe
`timescale 1ns/1ps
module hmpc_hall_filter #(
	parameter int DT_W = 8
) (
	input  wire logic            clk,
	input  wire logic            srst,
	input  wire logic [2:0]      hall_in,
	input  wire logic [DT_W-1:0] reload,
	output logic                 ready
);
	typedef struct packed {
		logic [2:0]      prev;
		logic [DT_W-1:0] cnt;
	} hmpc_flt_st_t;

	hmpc_flt_st_t s_r;
	hmpc_flt_st_t s_nxt;
	logic         edge_det;

	// edge reloads and restarts the counter, ready at count one
	always_comb
	begin
		s_nxt      = s_r;
		edge_det   = (hall_in != s_r.prev);
		s_nxt.prev = hall_in;
		if (edge_det)
			s_nxt.cnt = (reload == '0) ? DT_W'(1) : reload;
		else if (s_r.cnt != '0)
			s_nxt.cnt = s_r.cnt - DT_W'(1);
		ready = (s_r.cnt == DT_W'(1));
	end

	// state register
	always_ff @(posedge clk)
	begin
		if (srst)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	property p_edge_delay;
		edge_det && reload == DT_W'(2) ##1 !edge_det |=> ready;
	endproperty
	a_edge_delay: assert property (p_edge_delay) else $error("ready not one count after reload");

endmodule

// >>> hmpc_xfer_sync.sv
// trigger selection and timer synchronisation of the pattern shadow transfer
`timescale 1ns/1ps
module hmpc_xfer_sync (
	input  wire logic                  clk,
	input  wire logic                  srst,
	input  wire logic [2:0]            trig_sel,
	input  wire logic [1:0]            sync_sel,
	input  wire logic                  che,
	input  wire hmpc_pkg::hmpc_tmr_ev_t ev,
	input  wire logic                  sw_req,
	output logic                       xfer,
	output logic                       rem
);
	typedef struct packed {
		logic rem;
	} hmpc_sync_st_t;

	hmpc_sync_st_t s_r;
	hmpc_sync_st_t s_nxt;
	logic          trig;
	logic          sync_ev;

	// trigger choice, reserved codes give nothing
	always_comb
	begin
		case (hmpc_pkg::hmpc_trig_t'(trig_sel))
			hmpc_pkg::TRG_CHE:    trig = che;
			hmpc_pkg::TRG_TB_PM:  trig = ev.tb_period;
			hmpc_pkg::TRG_TA_OM:  trig = ev.ta_one_down;
			hmpc_pkg::TRG_CH1_UP: trig = ev.ta_ch1_up;
			hmpc_pkg::TRG_TA_PM:  trig = ev.ta_period_up;
			default:              trig = 1'b0;
		endcase
	end

	// synchronisation event and transfer decision
	always_comb
	begin
		s_nxt = s_r;
		case (hmpc_pkg::hmpc_sync_t'(sync_sel))
			hmpc_pkg::SYN_TB_ZM: sync_ev = ev.tb_zero;
			hmpc_pkg::SYN_TA_ZM: sync_ev = ev.ta_zero_up;
			default:             sync_ev = 1'b0;
		endcase
		if (sync_sel == hmpc_pkg::SYN_DIRECT)
			xfer = sw_req | trig;
		else
			xfer = sw_req | ((s_r.rem | trig) & sync_ev);
		// set wins over clear, unless the trigger transfers at once without a software request
		if (trig && sync_sel != hmpc_pkg::SYN_DIRECT && !(xfer && !sw_req))
			s_nxt.rem = 1'b1;
		else if (xfer)
			s_nxt.rem = 1'b0;
		rem = s_r.rem;
	end

	// state register
	always_ff @(posedge clk)
	begin
		if (srst)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	property p_direct;
		trig && sync_sel == 2'b00 |-> xfer;
	endproperty
	a_direct: assert property (p_direct) else $error("direct trigger without transfer");

	property p_rsvd;
		sync_sel == 2'b11 && !sw_req |-> !xfer;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("transfer on reserved sync");

	property p_wait_tb;
		trig && sync_sel == 2'b01 && !ev.tb_zero && !sw_req |-> !xfer ##1 rem;
	endproperty
	a_wait_tb: assert property (p_wait_tb) else $error("sync wait not held");

endmodule

// >>> hmpc_top.sv
// hall multichannel pattern control with apb register file
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module hmpc_top #(
	parameter int DT_W = 8
) (
	input  wire logic                   SYS_CLK,
	input  wire logic                   SRST,
	input  wire logic                   PSEL,
	input  wire logic                   PENABLE,
	input  wire logic                   PWRITE,
	input  wire logic [7:0]             PADDR,
	input  wire logic [31:0]            PWDATA,
	output logic      [31:0]            PRDATA,
	output logic                        PREADY,
	output logic                        PSLVERR,
	input  wire logic [2:0]             HALL_IN,
	input  wire hmpc_pkg::hmpc_tmr_ev_t TIMER_EV,
	input  wire logic [5:0]             TA_PWM,
	input  wire logic                   TB_PWM,
	input  wire logic                   TB_COMPARE_IN,
	output logic      [5:0]             OUT_LINES,
	output logic                        TB_COMPARE_OUT,
	output logic                        CORRECT_HALL_EVENT,
	output logic                        WRONG_HALL_EVENT,
	output logic                        PATTERN_SHADOW_TRANSFER
);
	typedef struct packed {
		logic [15:0]            modctl;
		logic [2:0]             sel;
		logic [1:0]             syn;
		hmpc_pkg::hmpc_pattern_t shadow;
		hmpc_pkg::hmpc_pattern_t active;
		logic [2:0]             sampled;
		logic                   f_xfer;
		logic                   f_che;
		logic                   f_whe;
		logic [DT_W-1:0]        dt_reload;
		logic                   che;
		logic                   whe;
		logic                   xfer;
		logic [5:0]             out;
		logic                   tbout;
		logic [31:0]            prdata;
	} hmpc_top_st_t;

	hmpc_top_st_t s_r;
	hmpc_top_st_t s_nxt;
	logic         ready;
	logic         xfer;
	logic         rem;
	logic         sw_preq;
	logic         sw_hreq;
	logic         setup;
	logic         wr;
	logic         hit;
	logic [31:0]  rd_word;
	logic [5:0]   ta_en;
	logic [5:0]   tb_en;
	logic [5:0]   src;
	logic         che_now;
	logic         whe_now;

	// ------------------------------------------------------------
	// hall input filter
	// ------------------------------------------------------------
	hmpc_hall_filter #(
		.DT_W (DT_W)
	) u_filter (
		.clk     (SYS_CLK),
		.srst    (SRST),
		.hall_in (HALL_IN),
		.reload  (s_r.dt_reload),
		.ready   (ready)
	);

	// ------------------------------------------------------------
	// pattern transfer trigger and synchronisation
	// ------------------------------------------------------------
	hmpc_xfer_sync u_sync (
		.clk      (SYS_CLK),
		.srst     (SRST),
		.trig_sel (s_r.sel),
		.sync_sel (s_r.syn),
		.che      (s_r.che),
		.ev       (TIMER_EV),
		.sw_req   (sw_preq),
		.xfer     (xfer),
		.rem      (rem)
	);

	// ------------------------------------------------------------
	// apb decode
	// ------------------------------------------------------------
	// zero wait states, unmapped access answers with an error
	always_comb
	begin
		setup   = PSEL & ~PENABLE;
		wr      = PSEL & PENABLE & PWRITE;
		hit     = 1'b1;
		rd_word = '0;
		if (PADDR == hmpc_pkg::OFS_MODCTL)
			rd_word[15:0] = s_r.modctl;
		else if (PADDR == hmpc_pkg::OFS_PCTRL)
		begin
			rd_word[hmpc_pkg::PC_SEL_LSB +: 3] = s_r.sel;
			rd_word[hmpc_pkg::PC_SYN_LSB +: 2] = s_r.syn;
		end
		else if (PADDR == hmpc_pkg::OFS_SHADOW)
		begin
			rd_word[hmpc_pkg::SH_PAT_LSB +: 6] = s_r.shadow.pat;
			rd_word[hmpc_pkg::SH_EXP_LSB +: 3] = s_r.shadow.exp;
			rd_word[hmpc_pkg::SH_CUR_LSB +: 3] = s_r.shadow.cur;
		end
		else if (PADDR == hmpc_pkg::OFS_ACTIVE)
		begin
			rd_word[hmpc_pkg::SH_PAT_LSB +: 6] = s_r.active.pat;
			rd_word[hmpc_pkg::SH_EXP_LSB +: 3] = s_r.active.exp;
			rd_word[hmpc_pkg::SH_CUR_LSB +: 3] = s_r.active.cur;
		end
		else if (PADDR == hmpc_pkg::OFS_STATUS)
		begin
			rd_word[hmpc_pkg::ST_XFER] = s_r.f_xfer;
			rd_word[hmpc_pkg::ST_CHE]  = s_r.f_che;
			rd_word[hmpc_pkg::ST_WHE]  = s_r.f_whe;
			rd_word[hmpc_pkg::ST_REM]  = rem;
			rd_word[hmpc_pkg::ST_HALL_LSB +: 3] = s_r.sampled;
		end
		else if (PADDR == hmpc_pkg::OFS_DTRELOAD)
			rd_word[DT_W-1:0] = s_r.dt_reload;
		else
			hit = 1'b0;
		PREADY  = 1'b1;
		PSLVERR = PSEL & PENABLE & ~hit;
	end

	// software transfer requests travel with the shadow write
	always_comb
	begin
		sw_preq = wr && PADDR == hmpc_pkg::OFS_SHADOW && PWDATA[hmpc_pkg::SH_PREQ];
		sw_hreq = wr && PADDR == hmpc_pkg::OFS_SHADOW && PWDATA[hmpc_pkg::SH_HREQ];
	end

	// ------------------------------------------------------------
	// hall compare
	// ------------------------------------------------------------
	// expected match has priority, current match is a spike
	always_comb
	begin
		che_now = ready && HALL_IN == s_r.active.exp;
		whe_now = ready && HALL_IN != s_r.active.exp
			&& HALL_IN != s_r.active.cur;
	end

	// ------------------------------------------------------------
	// output modulation
	// ------------------------------------------------------------
	// bit 5..0: ch2 inv, ch2 dir, ch1 inv, ch1 dir, ch0 inv, ch0 dir
	always_comb
	begin
		ta_en = s_r.modctl[hmpc_pkg::MC_TA_LSB +: 6];
		tb_en = s_r.modctl[hmpc_pkg::MC_TB_LSB +: 6];
		src   = (ta_en & TA_PWM) | (tb_en & {6{TB_PWM}});
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		s_nxt = s_r;
		// register writes take effect in the access phase
		if (wr && PADDR == hmpc_pkg::OFS_MODCTL)
			s_nxt.modctl = PWDATA[15:0] & hmpc_pkg::MODCTL_WMASK;
		if (wr && PADDR == hmpc_pkg::OFS_PCTRL)
		begin
			s_nxt.sel = PWDATA[hmpc_pkg::PC_SEL_LSB +: 3];
			s_nxt.syn = PWDATA[hmpc_pkg::PC_SYN_LSB +: 2];
		end
		if (wr && PADDR == hmpc_pkg::OFS_SHADOW)
		begin
			s_nxt.shadow.pat = PWDATA[hmpc_pkg::SH_PAT_LSB +: 6];
			s_nxt.shadow.exp = PWDATA[hmpc_pkg::SH_EXP_LSB +: 3];
			s_nxt.shadow.cur = PWDATA[hmpc_pkg::SH_CUR_LSB +: 3];
		end
		if (wr && PADDR == hmpc_pkg::OFS_DTRELOAD)
			s_nxt.dt_reload = PWDATA[DT_W-1:0];
		// status flags: write one clears, hardware set wins
		if (wr && PADDR == hmpc_pkg::OFS_STATUS)
		begin
			if (PWDATA[hmpc_pkg::ST_XFER])
				s_nxt.f_xfer = 1'b0;
			if (PWDATA[hmpc_pkg::ST_CHE])
				s_nxt.f_che = 1'b0;
			if (PWDATA[hmpc_pkg::ST_WHE])
				s_nxt.f_whe = 1'b0;
		end
		if (xfer)
			s_nxt.f_xfer = 1'b1;
		if (s_r.che)
			s_nxt.f_che = 1'b1;
		if (s_r.whe)
			s_nxt.f_whe = 1'b1;
		// sample and compare on the ready strobe only
		if (ready)
			s_nxt.sampled = HALL_IN;
		s_nxt.che = che_now;
		s_nxt.whe = whe_now;
		// hall patterns move on correct event or software request
		if (s_r.che || sw_hreq)
		begin
			s_nxt.active.exp = s_nxt.shadow.exp;
			s_nxt.active.cur = s_nxt.shadow.cur;
		end
		// modulation pattern moves only on the transfer signal
		if (xfer)
			s_nxt.active.pat = s_nxt.shadow.pat;
		s_nxt.xfer = xfer;
		// pattern mode gates the outputs with the active pattern
		if (s_r.modctl[hmpc_pkg::MC_EN])
			s_nxt.out = (src | ~(ta_en | tb_en)) & s_r.active.pat;
		else
			s_nxt.out = src;
		s_nxt.tbout = s_r.modctl[hmpc_pkg::MC_ECT] & TB_COMPARE_IN;
		if (setup)
			s_nxt.prdata = rd_word;
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge SYS_CLK)
	begin
		if (SRST)
		begin
			s_r           <= '0;
			s_r.modctl    <= hmpc_pkg::MODCTL_RST;
			s_r.sel       <= hmpc_pkg::SEL_RST;
			s_r.syn       <= hmpc_pkg::SYN_RST;
			s_r.dt_reload <= DT_W'(hmpc_pkg::DT_RELOAD_RST);
		end
		else
			s_r <= s_nxt;
	end

	// registered outputs
	always_comb
	begin
		PRDATA                  = s_r.prdata;
		OUT_LINES               = s_r.out;
		TB_COMPARE_OUT          = s_r.tbout;
		CORRECT_HALL_EVENT      = s_r.che;
		WRONG_HALL_EVENT        = s_r.whe;
		PATTERN_SHADOW_TRANSFER = s_r.xfer;
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (SRST);

	property p_correct;
		ready && HALL_IN == s_r.active.exp |=> CORRECT_HALL_EVENT && !WRONG_HALL_EVENT;
	endproperty
	a_correct: assert property (p_correct) else $error("missing correct event");

	property p_wrong;
		ready && HALL_IN != s_r.active.exp && HALL_IN != s_r.active.cur |=> WRONG_HALL_EVENT;
	endproperty
	a_wrong: assert property (p_wrong) else $error("missing wrong event");

	property p_spike;
		ready && HALL_IN == s_r.active.cur && HALL_IN != s_r.active.exp
			|=> !CORRECT_HALL_EVENT && !WRONG_HALL_EVENT;
	endproperty
	a_spike: assert property (p_spike) else $error("event on spike");

	property p_no_ready;
		!ready |=> !CORRECT_HALL_EVENT && !WRONG_HALL_EVENT && $stable(s_r.sampled);
	endproperty
	a_no_ready: assert property (p_no_ready) else $error("compare without ready");

	property p_hall_copy;
		CORRECT_HALL_EVENT && !wr |=> s_r.active.cur == $past(s_r.shadow.cur)
			&& s_r.active.exp == $past(s_r.shadow.exp);
	endproperty
	a_hall_copy: assert property (p_hall_copy) else $error("hall patterns not copied");

	property p_pat_hold;
		!xfer |=> $stable(s_r.active.pat) ##0 !PATTERN_SHADOW_TRANSFER;
	endproperty
	a_pat_hold: assert property (p_pat_hold) else $error("pattern moved without transfer");

	property p_ect;
		!s_r.modctl[hmpc_pkg::MC_ECT] |=> !TB_COMPARE_OUT;
	endproperty
	a_ect: assert property (p_ect) else $error("timer_b output not forced low");

	property p_mask;
		s_r.modctl[hmpc_pkg::MC_EN] |=> (OUT_LINES & ~$past(s_r.active.pat)) == 6'h0;
	endproperty
	a_mask: assert property (p_mask) else $error("output outside active pattern");

	property p_sw_hall;
		sw_hreq |=> s_r.active.exp == $past(PWDATA[10:8]);
	endproperty
	a_sw_hall: assert property (p_sw_hall) else $error("software hall transfer lost");

	// transfer raises both the sticky flag and the pulse
	property p_xfer_flag;
		xfer |=> s_r.f_xfer && PATTERN_SHADOW_TRANSFER;
	endproperty
	a_xfer_flag: assert property (p_xfer_flag) else $error("transfer not flagged");

	// no enable and no pattern mode leaves the outputs idle
	property p_mod_off;
		!s_r.modctl[hmpc_pkg::MC_EN] && ta_en == 6'h00 && tb_en == 6'h00 |=> OUT_LINES == 6'h00;
	endproperty
	a_mod_off: assert property (p_mod_off) else $error("output active without source");

	// one compare gives one kind of event at most
	property p_excl;
		!(CORRECT_HALL_EVENT && WRONG_HALL_EVENT);
	endproperty
	a_excl: assert property (p_excl) else $error("correct and wrong event together");

	// the ready strobe captures the sensor levels
	property p_sampled;
		ready |=> s_r.sampled == $past(HALL_IN);
	endproperty
	a_sampled: assert property (p_sampled) else $error("hall inputs not sampled");

	// hall patterns move only on a correct event or a software request
	property p_hall_hold;
		!CORRECT_HALL_EVENT && !sw_hreq |=> $stable(s_r.active.exp) && $stable(s_r.active.cur);
	endproperty
	a_hall_hold: assert property (p_hall_hold) else $error("hall patterns moved");

	// enabled timer_b compare output follows its input
	property p_tb_pass;
		s_r.modctl[hmpc_pkg::MC_ECT] |=> TB_COMPARE_OUT == $past(TB_COMPARE_IN);
	endproperty
	a_tb_pass: assert property (p_tb_pass) else $error("timer_b output not passed");

	c_correct: cover property (CORRECT_HALL_EVENT ##[1:20] PATTERN_SHADOW_TRANSFER);
	c_mask:    cover property (s_r.modctl[hmpc_pkg::MC_EN] && OUT_LINES != 6'h00);
	c_wrong:   cover property (WRONG_HALL_EVENT);
	c_sync:    cover property (rem ##1 xfer && s_r.syn == 2'b01);

endmodule

// >>> hmpc_hall_model.sv
// behavioural hall sensor set driving the three position lines
`timescale 1ns/1ps
module hmpc_hall_model (
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic [2:0] pos,
	input  wire logic       spike,
	output logic      [2:0] hall
);
	// sensor lines follow the rotor, a spike shows the inverse for one cycle
	always_ff @(posedge clk)
	begin
		if (srst)
			hall <= 3'h0;
		else if (spike)
			hall <= ~pos;
		else
			hall <= pos;
	end
endmodule

// >>> tb_top.sv
// self-checking bench for the hall pattern control block
`timescale 1ns/1ps
module tb_top;
	logic                   sys_clk;
	logic                   srst;
	logic                   psel;
	logic                   penable;
	logic                   pwrite;
	logic [7:0]             paddr;
	logic [31:0]            pwdata;
	logic [31:0]            prdata;
	logic                   pready;
	logic                   pslverr;
	logic [2:0]             hall;
	logic [2:0]             pos;
	logic                   spike;
	hmpc_pkg::hmpc_tmr_ev_t tev;
	logic [5:0]             ta_pwm;
	logic                   tb_pwm;
	logic                   cmp_in;
	logic [5:0]             out_lines;
	logic                   cmp_out;
	logic                   che;
	logic                   whe;
	logic                   xfer;
	logic [31:0]            rd;
	logic                   err;
	logic [5:0]             act_pat;
	logic [5:0]             pat;
	logic [15:0]            ctl;
	int                     mismatches = 0;
	int                     checks_done = 0;
	int                     che_n = 0;
	int                     whe_n = 0;
	int                     xfer_n = 0;
	int                     n0;
	int                     seed;

	hmpc_top #(.DT_W(8)) DUT (
		.SYS_CLK(sys_clk), .SRST(srst), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .HALL_IN(hall), .TIMER_EV(tev),
		.TA_PWM(ta_pwm), .TB_PWM(tb_pwm), .TB_COMPARE_IN(cmp_in),
		.OUT_LINES(out_lines), .TB_COMPARE_OUT(cmp_out), .CORRECT_HALL_EVENT(che),
		.WRONG_HALL_EVENT(whe), .PATTERN_SHADOW_TRANSFER(xfer)
	);

	hmpc_hall_model sensors (.clk(sys_clk), .srst(srst), .pos(pos), .spike(spike), .hall(hall));

	// clock at 50 MHz
	initial
	begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	// count event pulses seen on the outputs
	always @(posedge sys_clk)
	begin
		che_n  <= che_n + (che !== 1'b0);
		whe_n  <= whe_n + (whe !== 1'b0);
		xfer_n <= xfer_n + (xfer !== 1'b0);
	end

	// ------------------------------------------------------------
	// shared tasks and expectations
	// ------------------------------------------------------------
	task automatic end_sim;
		$display("mismatches %0d checks %0d", mismatches, checks_done);
		if (mismatches == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do
		begin
			@(posedge sys_clk);
		end
		while (pready !== 1'b1);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic pulse(input logic [5:0] v);
		@(posedge sys_clk);
		tev <= v;
		@(posedge sys_clk);
		tev <= 6'h00;
	endtask

	// move the rotor or spike it, then count compare events
	task automatic hall_go(input logic [2:0] p, input logic s, input int dc, input int dw);
		int c0;
		int w0;
		c0 = che_n;
		w0 = whe_n;
		@(posedge sys_clk);
		pos   <= p;
		spike <= s;
		@(posedge sys_clk);
		spike <= 1'b0;
		repeat (14) @(posedge sys_clk);
		chk(che_n - c0, dc);
		chk(whe_n - w0, dw);
	endtask

	function automatic logic [5:0] trig_bit(input int code);
		case (code)
			2: return 6'h20;
			3: return 6'h10;
			4: return 6'h08;
			5: return 6'h04;
			default: return 6'h00;
		endcase
	endfunction

	function automatic logic [5:0] exp_out(input logic [15:0] c, input logic [5:0] p,
		input logic [5:0] ta, input logic tb);
		logic [5:0] pwm;
		logic [5:0] en;
		pwm = (c[5:0] & ta) | (c[13:8] & {6{tb}});
		en  = c[5:0] | c[13:8];
		if (c[7])
			return (pwm | ~en) & p;
		return pwm;
	endfunction

	// watchdog cuts a hang short
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		mismatches++;
		end_sim;
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		int k;
		int s;
		int r;
		seed = 63;
		srst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		pos = 3'h0;
		spike = 1'b0;
		tev = 6'h00;
		ta_pwm = 6'h00;
		tb_pwm = 1'b0;
		cmp_in = 1'b0;
		repeat (12) @(posedge sys_clk);
		srst <= 1'b0;
		// reset values, read-only and unmapped places
		apb(1'b0, hmpc_pkg::OFS_MODCTL, 32'h0);
		chk(rd, 32'h0000_0000);
		apb(1'b0, hmpc_pkg::OFS_DTRELOAD, 32'h0);
		chk(rd, 32'h0000_0004);
		apb(1'b1, hmpc_pkg::OFS_ACTIVE, 32'hFFFF_FFFF);
		apb(1'b0, hmpc_pkg::OFS_ACTIVE, 32'h0);
		chk(rd, 32'h0000_0000);
		apb(1'b0, 8'h18, 32'h0);
		chk(rd, 32'h0000_0000);
		chk(err, 1'b1);
		for (k = 0; k < 4; k++)
		begin
			r = $random(seed);
			apb(1'b1, hmpc_pkg::OFS_MODCTL, r);
			apb(1'b0, hmpc_pkg::OFS_MODCTL, 32'h0);
			chk(rd, r & {16'h0000, hmpc_pkg::MODCTL_WMASK});
		end
		// hall compare with a random dead time
		r = $random(seed);
		apb(1'b1, hmpc_pkg::OFS_DTRELOAD, {29'h0, r[2:0]} | 32'h1);
		apb(1'b0, hmpc_pkg::OFS_DTRELOAD, 32'h0);
		chk(rd, {29'h0, r[2:0]} | 32'h1);
		apb(1'b1, hmpc_pkg::OFS_SHADOW, 32'h0000_8B00);
		apb(1'b0, hmpc_pkg::OFS_ACTIVE, 32'h0);
		chk(rd, 32'h0000_0B00);
		hall_go(3'b001, 1'b0, 0, 0);
		hall_go(3'b001, 1'b1, 0, 0);
		apb(1'b1, hmpc_pkg::OFS_PCTRL, 32'h0000_0001);
		apb(1'b1, hmpc_pkg::OFS_SHADOW, 32'h0000_1A21);
		n0 = xfer_n;
		hall_go(3'b011, 1'b0, 1, 0);
		chk(xfer_n - n0, 1);
		apb(1'b0, hmpc_pkg::OFS_ACTIVE, 32'h0);
		chk(rd, 32'h0000_1A21);
		act_pat = 6'h21;
		apb(1'b0, hmpc_pkg::OFS_STATUS, 32'h0);
		chk(rd, 32'h0000_0033);
		apb(1'b1, hmpc_pkg::OFS_STATUS, 32'h0000_0001);
		apb(1'b0, hmpc_pkg::OFS_STATUS, 32'h0);
		chk(rd[0], 0);
		hall_go(3'b101, 1'b0, 0, 1);
		// reload of two walks a two-count filter delay, one above the shortest
		apb(1'b1, hmpc_pkg::OFS_DTRELOAD, 32'h0000_0002);
		hall_go(3'b010, 1'b0, 1, 0);
		// every trigger code in direct mode, other events pulsed first
		for (k = 0; k < 8; k++)
		begin
			apb(1'b1, hmpc_pkg::OFS_PCTRL, k);
			pat = $random(seed);
			apb(1'b1, hmpc_pkg::OFS_SHADOW, {26'h0, pat});
			n0 = xfer_n;
			pulse(~trig_bit(k) & 6'h3C);
			pulse(trig_bit(k));
			repeat (3) @(posedge sys_clk);
			chk(xfer_n - n0, trig_bit(k) != 0);
			if (trig_bit(k) != 0)
				act_pat = pat;
			apb(1'b0, hmpc_pkg::OFS_ACTIVE, 32'h0);
			chk(rd[5:0], act_pat);
		end
		// synchronised modes after a timer_b period trigger
		for (k = 0; k < 3; k++)
		begin
			s = (k == 0) ? 3 : k;
			apb(1'b1, hmpc_pkg::OFS_PCTRL, (s << 4) | 2);
			pat = $random(seed);
			apb(1'b1, hmpc_pkg::OFS_SHADOW, {26'h0, pat});
			n0 = xfer_n;
			pulse(6'h20);
			pulse((s == 1) ? 6'h01 : (s == 2) ? 6'h02 : 6'h03);
			repeat (2) @(posedge sys_clk);
			chk(xfer_n - n0, 0);
			apb(1'b0, hmpc_pkg::OFS_STATUS, 32'h0);
			if (s != 3)
			begin
				chk(rd[3], 1);
				pulse((s == 1) ? 6'h02 : 6'h01);
				repeat (2) @(posedge sys_clk);
				apb(1'b0, hmpc_pkg::OFS_STATUS, 32'h0);
				chk(rd[3], 0);
			end
			else
				apb(1'b1, hmpc_pkg::OFS_SHADOW, {26'h2, pat});
			repeat (2) @(posedge sys_clk);
			chk(xfer_n - n0, 1);
			act_pat = pat;
			apb(1'b0, hmpc_pkg::OFS_ACTIVE, 32'h0);
			chk(rd[5:0], act_pat);
		end
		// output modulation with one timer source at a time
		for (k = 0; k < 8; k++)
		begin
			r = $random(seed);
			ctl = r[15:0] & hmpc_pkg::MODCTL_WMASK;
			if (r[20])
				ctl[13:8] = 6'h00;
			else
				ctl[5:0] = 6'h00;
			if (k == 0)
				ctl = 16'h0080;
			r = $random(seed);
			ta_pwm <= r[5:0];
			tb_pwm <= r[6];
			cmp_in <= r[7];
			apb(1'b1, hmpc_pkg::OFS_MODCTL, {16'h0, ctl});
			repeat (3) @(posedge sys_clk);
			chk(out_lines, exp_out(ctl, act_pat, ta_pwm, tb_pwm));
			chk(cmp_out, ctl[15] & cmp_in);
		end
		end_sim;
	end
endmodule
